/* dv/gdfs_board_model.sv */
// Board model at the far side of the supervisor: external gates and the fault pin pull-up.
// Assumes the supervisor's core clock; it has no reset of its own.
`timescale 1ns/1ns
module gdfs_board_model (
  input  wire logic       i_core_clk,
  input  wire logic [5:0] i_gate_drive,
  input  wire logic [5:0] i_stuck_low,
  input  wire logic       i_pin_oe,
  output logic      [5:0] o_gate_fb,
  output logic            o_pin_level
);
  logic [5:0] dly_q [4] = '{default: 6'h00};
  logic [5:0] fb_q      = 6'h00;

  // Gates lag the drive by a few cycles as they charge.
  // A stuck bit models a gate shorted to ground.
  always_ff @(posedge i_core_clk) begin
    dly_q[0] <= i_gate_drive;
    for (int k = 1; k < 4; k++) begin
      dly_q[k] <= dly_q[k-1];
    end
    fb_q <= dly_q[3] & ~i_stuck_low;
  end
  assign o_gate_fb = fb_q;
  // The pin is open drain, so it reads high whenever nobody pulls it.
  assign o_pin_level = i_pin_oe ? 1'b0 : 1'b1;
endmodule

/* dv/test_gdfs_top.sv */
// Self-checking bench for the gate driver fault supervisor.
// Assumes the board model for gates and pin, and a 20-cycle warning pulse length.
`timescale 1ns/1ns
module test_gdfs_top;
  import gdfs_pkg::*;
  localparam int PC = 20;
  typedef struct {logic [3:0] a; logic [15:0] d; logic [15:0] e;} gdfs_row_t;
  logic        clk   = 1'b0;
  logic        rst   = 1'b1;
  logic [3:0]  addr  = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr    = 1'b0;
  logic        rd    = 1'b0;
  logic [5:0]  pwm   = 6'h00;
  logic        gen   = 1'b1;
  logic [3:0]  warn  = 4'h0;
  logic [1:0]  therm = 2'h0;
  logic [2:0]  flt   = 3'h0;
  logic        win   = 1'b1;
  logic        wdog  = 1'b0;
  logic [5:0]  stuck = 6'h00;
  logic [15:0] rdata, v;
  logic [5:0]  fb, drv, hold, hiz, gain;
  logic [2:0]  cal;
  logic        blank, bias, oe, sg, pin, pin_o;
  logic [3:0]  mon;
  logic [3:0]  ra [6] = '{4'h1, 4'h2, 4'h5, 4'h6, 4'h9, 4'ha};
  int          fails  = 0;
  int          checks = 0;
  int          cycles = 0;
  int          n;
  gdfs_row_t   rows [11] = '{'{4'ha, 16'h0000, 16'h0000}, '{4'ha, 16'h00e4, 16'h00e4},
    '{4'ha, 16'h071b, 16'h071b}, '{4'h5, 16'h0100, 16'h0100}, '{4'h6, 16'h0300, 16'h0300},
    '{4'h9, 16'h0100, 16'h0100}, '{4'h3, 16'hffff, 16'h0000}, '{4'h9, 16'h0000, 16'h0000},
    '{4'h5, 16'h0000, 16'h0000}, '{4'h6, 16'h0000, 16'h0000}, '{4'ha, 16'h0000, 16'h0000}};

  gdfs_top #(.PULSE_CYCLES(PC)) u_gdfs_top (.i_core_clk(clk), .i_reset(rst), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_pwm_cmd(pwm), .i_gate_fb(fb),
    .i_gate_enable(gen), .i_warn_cond(warn), .i_thermal_flags(therm), .i_fault_cond(flt),
    .i_reg_window_ok(win), .i_watchdog_fault(wdog), .o_gate_drive(drv),
    .o_hold_current(hold), .o_gate_hiz(hiz), .o_csa_blank(blank), .o_csa_gain(gain),
    .o_csa_bias_quarter(bias), .o_csa_cal(cal), .o_error_indicator_pin_oe(oe),
    .o_error_indicator_pin_o(pin_o), .o_supply_good_output(sg));
  gdfs_board_model u_gdfs_board_model (.i_core_clk(clk), .i_gate_drive(drv),
    .i_stuck_low(stuck), .i_pin_oe(oe), .o_gate_fb(fb), .o_pin_level(pin));

  always #2 clk = ~clk;
  assign mon = {hold[0], sg, blank, pin};

  task automatic tally_and_finish;
    if (fails == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    checks++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk) begin addr <= a; wdata <= d; wr <= 1'b1; end
    @(posedge clk) wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a);
    @(posedge clk) begin addr <= a; rd <= 1'b1; end
    @(posedge clk) rd <= 1'b0;
    #1 v = rdata;
  endtask
  // Counts settled cycles until the watched output reaches the level, or the limit.
  task automatic waitv(input int i, input logic b, input int lim);
    n = 0;
    while (mon[i] !== b && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  initial begin
    repeat (2) @(posedge clk);
    #1 chk("hiz", 16'h003f, {10'h0, hiz});
    @(posedge clk) rst <= 1'b0;
    waitv(2, 1'b1, 200);
    foreach (ra[i]) begin
      rreg(ra[i]);
      chk("reset reg", 16'h0000, v);
    end
    foreach (rows[i]) begin
      wreg(rows[i].a, rows[i].d);
      rreg(rows[i].a);
      chk("reg", rows[i].e, v);
      if (rows[i].a == 4'ha) chk("csa", rows[i].d & 16'h077f, {5'h0, cal, 1'b0, bias, gain});
    end
    @(posedge clk) pwm <= 6'h01;
    cyc(30);
    chk("early", 16'h0000, {14'h0, hold[0], blank});
    waitv(3, 1'b1, 60);
    chk("hold", 16'h0001, {hiz, 9'h0, hold[0]});
    @(posedge clk) pwm <= 6'h00;
    cyc(10);
    @(posedge clk) pwm <= 6'h01;
    cyc(10);
    @(posedge clk) pwm <= 6'h00;
    cyc(100);
    rreg(4'h1);
    chk("cut timer", 16'h0001, v | {15'h0, pin});
    wreg(4'ha, 16'h0080);
    @(posedge clk) pwm <= 6'h08;
    waitv(1, 1'b1, 10);
    chk("blank", 16'h0001, {15'h0, blank});
    cyc(50);
    @(posedge clk) pwm <= 6'h00;
    cyc(70);
    chk("reblank", 16'h0001, {15'h0, blank});
    waitv(1, 1'b0, 60);
    chk("unblank", 16'h0000, {15'h0, blank});
    wreg(4'ha, 16'h0000);
    @(posedge clk) begin stuck <= 6'h01; pwm <= 6'h01; end
    waitv(0, 1'b0, 100);
    cyc(40);
    chk("fault pins", 16'h003f, {pin, drv, 3'h0, hiz});
    chk("pin level out", 16'h0000, {15'h0, pin_o});
    rreg(4'h1);
    chk("status1", 16'h0401, v & 16'h0401);
    @(posedge clk) begin stuck <= 6'h00; pwm <= 6'h00; end
    cyc(10);
    wreg(4'h9, 16'h0002);
    waitv(0, 1'b1, 20);
    rreg(4'h9);
    chk("clr", 16'h0001, v | {15'h0, pin});
    wreg(4'h9, 16'h0100);
    @(posedge clk) begin stuck <= 6'h01; pwm <= 6'h01; end
    cyc(150);
    chk("no gate chk", 16'h0041, {9'h0, pin, drv});
    @(posedge clk) begin stuck <= 6'h00; pwm <= 6'h00; end
    wreg(4'h9, 16'h0000);
    @(posedge clk) warn <= 4'h1;
    waitv(0, 1'b0, 20);
    waitv(0, 1'b1, 60);
    chk("low time", 16'(PC), 16'(n));
    waitv(0, 1'b0, 60);
    chk("high time", 16'(PC), {hiz, drv, 4'h0} | 16'(n));
    rreg(4'h2);
    chk("warn", 16'h0001, v & 16'h0001);
    cyc(3);
    waitv(0, 1'b0, 3 * PC);
    rreg(4'h2);
    chk("acked", 16'h0003, {14'h0, pin, v[0]});
    @(posedge clk) warn <= 4'h0;
    cyc(10);
    rreg(4'h2);
    chk("warn gone", 16'h0000, v & 16'h0001);
    @(posedge clk) warn <= 4'h1;
    waitv(0, 1'b0, 20);
    chk("rewarn", 16'h0000, {15'h0, pin});
    @(posedge clk) flt <= 3'h1;
    cyc(10);
    waitv(0, 1'b1, 3 * PC);
    chk("fault wins", 16'h003f, {pin, drv, 3'h0, hiz});
    rreg(4'h1);
    chk("type", 16'h0440, v & 16'h0440);
    @(posedge clk) begin flt <= 3'h0; warn <= 4'h0; end
    cyc(10);
    rreg(4'h2);
    @(posedge clk) gen <= 1'b0;
    cyc(10);
    @(posedge clk) gen <= 1'b1;
    waitv(0, 1'b1, 30);
    chk("enable rec", 16'h0001, {15'h0, pin});
    @(posedge clk) therm <= 2'h3;
    cyc(10);
    rreg(4'h2);
    chk("thermal", 16'h0031, (v & 16'h0030) | {15'h0, pin});
    @(posedge clk) therm <= 2'h0;
    cyc(10);
    rreg(4'h2);
    chk("thermal off", 16'h0000, v & 16'h0030);
    @(posedge clk) win <= 1'b0;
    cyc(2);
    @(posedge clk) win <= 1'b1;
    waitv(2, 1'b0, 10);
    waitv(2, 1'b1, 60);
    chk("sg low", 16'(PC), 16'(n));
    @(posedge clk) win <= 1'b0;
    cyc(60);
    chk("sg held", 16'h0000, {15'h0, sg});
    @(posedge clk) win <= 1'b1;
    waitv(2, 1'b1, PC + 10);
    chk("sg back", 16'h0001, {15'h0, sg});
    @(posedge clk) wdog <= 1'b1;
    waitv(2, 1'b0, 20);
    chk("watchdog", 16'h0001, {14'h0, sg, pin});
    @(posedge clk) wdog <= 1'b0;
    cyc(60);
    tally_and_finish();
  end
endmodule

/* rtl/gdfs_pkg.sv */
// Package for the gate driver fault supervisor: register map, fields, timing.
// Assumes a 250 MHz core clock and a simple strobe register port.
package gdfs_pkg;
  localparam int unsigned CLK_MHZ        = 250;
  localparam int unsigned PULSE_US       = 56;
  localparam int unsigned PULSE_CYC      = PULSE_US * CLK_MHZ;
  localparam logic [3:0]  ADDR_STAT1     = 4'h1;
  localparam logic [3:0]  ADDR_STAT2     = 4'h2;
  localparam logic [3:0]  ADDR_LS_DRV    = 4'h5;
  localparam logic [3:0]  ADDR_HS_DRV    = 4'h6;
  localparam logic [3:0]  ADDR_CTRL      = 4'h9;
  localparam logic [3:0]  ADDR_CSA       = 4'ha;
  localparam int unsigned TDRV_LSB       = 8;
  localparam int unsigned CLR_BIT        = 1;
  localparam int unsigned GCHK_DIS_BIT   = 8;
  localparam int unsigned FAULT_SUM_BIT  = 10;
  localparam logic [10:0] CSA_RESET      = 11'h000;
  localparam logic [15:0] LS_DRV_RESET   = 16'h0000;
  localparam logic [15:0] HS_DRV_RESET   = 16'h0000;
  localparam logic [15:0] CTRL_RESET     = 16'h0000;
  localparam int unsigned GAIN_LSB       = 0;
  localparam int unsigned BIAS_BIT       = 6;
  localparam int unsigned BLANK_LSB      = 7;
  localparam int unsigned CAL_LSB        = 8;
  localparam logic [15:0] GATE_DRIVE_TIMER_CYC0    = 16'h0032;
  localparam logic [15:0] GATE_DRIVE_TIMER_CYC1    = 16'h0064;
  localparam logic [15:0] GATE_DRIVE_TIMER_CYC2    = 16'h00fa;
  localparam logic [15:0] GATE_DRIVE_TIMER_CYC3    = 16'h01f4;
  localparam logic [15:0] BLANK_CYC1     = 16'h0064;
  localparam logic [15:0] BLANK_CYC2     = 16'h00c8;
  localparam logic [15:0] BLANK_CYC3     = 16'h0190;
  typedef enum logic [1:0] {GD_IDLE, GD_STRONG, GD_HOLD, GD_FAIL} gdfs_gate_t;
endpackage

/* rtl/gdfs_top.sv */
// Supervisor logic of a three-phase gate driver: drive timer, blanking, faults.
// Assumes gate feedback and condition inputs come from analog pins off-clock.
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/1ns
module gdfs_top
  import gdfs_pkg::*;
#(
  parameter int unsigned PULSE_CYCLES = PULSE_CYC
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_reset,
  input  wire logic [3:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [15:0] o_rdata,
  input  wire logic [5:0]  i_pwm_cmd,
  input  wire logic [5:0]  i_gate_fb,
  input  wire logic        i_gate_enable,
  input  wire logic [3:0]  i_warn_cond,
  input  wire logic [1:0]  i_thermal_flags,
  input  wire logic [2:0]  i_fault_cond,
  input  wire logic        i_reg_window_ok,
  input  wire logic        i_watchdog_fault,
  output logic      [5:0]  o_gate_drive,
  output logic      [5:0]  o_hold_current,
  output logic      [5:0]  o_gate_hiz,
  output logic             o_csa_blank,
  output logic      [5:0]  o_csa_gain,
  output logic             o_csa_bias_quarter,
  output logic      [2:0]  o_csa_cal,
  output logic             o_error_indicator_pin_oe,
  output logic             o_error_indicator_pin_o,
  output logic             o_supply_good_output
);
  localparam int NS = 16;
  // Every stage resets to the idle pin levels so no false edge follows reset.
  localparam logic [NS-1:0] SYNC_IDLE = {1'b1, 15'h0000};
  logic [NS-1:0] sy1_q, sy2_q, sy3_q, st_q;
  logic [NS-1:0] raw;
  assign raw = {i_reg_window_ok, i_fault_cond, i_thermal_flags, i_warn_cond, i_gate_fb};
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      sy1_q <= SYNC_IDLE;
      sy2_q <= SYNC_IDLE;
      sy3_q <= SYNC_IDLE;
      st_q  <= SYNC_IDLE;
    end else begin
      sy1_q <= raw;
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
      for (int k = 0; k < NS; k++) begin
        if (sy2_q[k] == sy3_q[k]) begin
          st_q[k] <= sy3_q[k];
        end
      end
    end
  end
  logic [5:0] fb;
  logic [3:0] warn;
  logic [1:0] therm;
  logic [2:0] fcond;
  logic       win_ok, en_s;
  assign fb     = st_q[5:0];
  assign warn   = st_q[9:6];
  assign therm  = st_q[11:10];
  assign fcond  = st_q[14:12];
  assign win_ok = st_q[15];
  // Enable and watchdog have their own chains; the enable feeds an edge detector.
  logic [2:0] en1_q;
  logic       en_q, wd_q;
  logic [2:0] wd1_q;
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      en1_q <= '0;
      en_q  <= 1'b0;
      wd1_q <= '0;
      wd_q  <= 1'b0;
    end else begin
      en1_q <= {en1_q[1:0], i_gate_enable};
      if (en1_q[1] == en1_q[2]) begin
        en_q <= en1_q[2];
      end
      wd1_q <= {wd1_q[1:0], i_watchdog_fault};
      if (wd1_q[1] == wd1_q[2]) begin
        wd_q <= wd1_q[2];
      end
    end
  end
  assign en_s = en_q;

  function automatic logic [15:0] gate_drive_timer_cyc(input logic [1:0] sel);
    case (sel)
      2'd0:    gate_drive_timer_cyc = GATE_DRIVE_TIMER_CYC0;
      2'd1:    gate_drive_timer_cyc = GATE_DRIVE_TIMER_CYC1;
      2'd2:    gate_drive_timer_cyc = GATE_DRIVE_TIMER_CYC2;
      default: gate_drive_timer_cyc = GATE_DRIVE_TIMER_CYC3;
    endcase
  endfunction

  // Registers.
  logic [15:0] ls_drv_q, hs_drv_q, ctrl_q;
  logic [10:0] csa_q;
  logic        fault_q, en_prev_q;
  logic [2:0]  ftype_q;
  logic [5:0]  gfail_q;
  logic [3:0]  wstat_q, wack_q;
  logic        clr_done;
  assign clr_done = ctrl_q[CLR_BIT] & ~fault_q;
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      ls_drv_q <= LS_DRV_RESET;
      hs_drv_q <= HS_DRV_RESET;
      ctrl_q   <= CTRL_RESET;
      csa_q    <= CSA_RESET;
    end else begin
      if (i_wr && i_addr == ADDR_LS_DRV) begin
        ls_drv_q <= i_wdata;
      end else if (i_wr && i_addr == ADDR_HS_DRV) begin
        hs_drv_q <= i_wdata;
      end else if (i_wr && i_addr == ADDR_CSA) begin
        csa_q <= i_wdata[10:0];
      end
      if (i_wr && i_addr == ADDR_CTRL) begin
        ctrl_q <= i_wdata;
      end else if (clr_done) begin
        ctrl_q[CLR_BIT] <= 1'b0;
      end
    end
  end

  // Gate drive timer per output: low sides are bits 2:0, high sides 5:3.
  gdfs_gate_t  gst_q [6];
  logic [15:0] gcnt_q [6];
  logic [5:0]  cmd_q;
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      cmd_q <= '0;
      for (int g = 0; g < 6; g++) begin
        gst_q[g]  <= GD_IDLE;
        gcnt_q[g] <= '0;
      end
    end else begin
      cmd_q <= i_pwm_cmd;
      for (int g = 0; g < 6; g++) begin
        if (fault_q) begin
          gst_q[g] <= GD_IDLE;
        end else if (i_pwm_cmd[g] != cmd_q[g]) begin
          gst_q[g]  <= GD_STRONG;
          gcnt_q[g] <= gate_drive_timer_cyc(g < 3 ? ls_drv_q[TDRV_LSB+:2] : hs_drv_q[TDRV_LSB+:2]);
        end else if (gst_q[g] == GD_STRONG) begin
          if (gcnt_q[g] > 16'h0001) begin
            gcnt_q[g] <= gcnt_q[g] - 16'h0001;
          end else if (fb[g] != cmd_q[g] && !ctrl_q[GCHK_DIS_BIT]) begin
            gst_q[g] <= GD_FAIL;
          end else begin
            gst_q[g] <= GD_HOLD;
          end
        end else if (gst_q[g] == GD_FAIL) begin
          gst_q[g] <= GD_IDLE;
        end
      end
    end
  end
  logic [5:0] gfail_now;
  always_comb begin
    for (int g = 0; g < 6; g++) begin
      gfail_now[g] = (gst_q[g] == GD_FAIL);
    end
  end

  // Fault latch and recovery.
  logic       any_fault, cond_gone;
  assign any_fault = |fcond | |gfail_now;
  assign cond_gone = ~|fcond;
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      fault_q   <= 1'b0;
      ftype_q   <= '0;
      gfail_q   <= '0;
      en_prev_q <= 1'b0;
    end else begin
      en_prev_q <= en_s;
      if (any_fault) begin
        fault_q <= 1'b1;
        ftype_q <= ftype_q | fcond;
        gfail_q <= gfail_q | gfail_now;
      end else if (cond_gone && (ctrl_q[CLR_BIT] || (en_prev_q && !en_s))) begin
        fault_q <= 1'b0;
        ftype_q <= '0;
        gfail_q <= '0;
      end
    end
  end

  // Warnings: status follows condition; read of status 2 acknowledges pin report.
  logic warn_ack_rd;
  assign warn_ack_rd = i_rd && i_addr == ADDR_STAT2;
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      wstat_q <= '0;
      wack_q  <= '0;
    end else begin
      wstat_q <= warn;
      for (int w = 0; w < 4; w++) begin
        if (!warn[w]) begin
          wack_q[w] <= 1'b0;
        end else if (warn_ack_rd && wstat_q[w]) begin
          wack_q[w] <= 1'b1;
        end
      end
    end
  end
  logic warn_pend;
  assign warn_pend = |(wstat_q & ~wack_q & warn);

  // Error pin: steady low on fault, 56 us low/high toggling for warnings.
  logic [15:0] wcnt_q;
  logic        wph_q;
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      wcnt_q <= '0;
      wph_q  <= 1'b0;
      o_error_indicator_pin_oe <= 1'b0;
      o_error_indicator_pin_o  <= 1'b0;
    end else begin
      o_error_indicator_pin_o <= 1'b0;
      if (fault_q || any_fault) begin
        o_error_indicator_pin_oe <= 1'b1;
        wcnt_q <= '0;
        wph_q  <= 1'b0;
      end else if (warn_pend) begin
        o_error_indicator_pin_oe <= ~wph_q;
        if (wcnt_q == 16'(PULSE_CYCLES - 1)) begin
          wcnt_q <= '0;
          wph_q  <= ~wph_q;
        end else begin
          wcnt_q <= wcnt_q + 16'h0001;
        end
      end else begin
        o_error_indicator_pin_oe <= 1'b0;
        wcnt_q <= '0;
        wph_q  <= 1'b0;
      end
    end
  end

  // Supply-good: fixed low period on window exit, then wait for recovery.
  logic [15:0] pcnt_q;
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      pcnt_q <= '0;
      o_supply_good_output <= 1'b0;
    end else begin
      if (!win_ok && o_supply_good_output) begin
        // The load edge already starts the low period, so one cycle less is counted.
        pcnt_q <= 16'(PULSE_CYCLES - 1);
        o_supply_good_output <= 1'b0;
      end else if (pcnt_q != 16'h0000) begin
        pcnt_q <= pcnt_q - 16'h0001;
      end else begin
        o_supply_good_output <= win_ok && !wd_q;
      end
    end
  end

  // Blanking of amplifier outputs on any gate edge.
  logic [15:0] bcnt_q;
  logic [15:0] blank_len;
  always_comb begin
    case (csa_q[BLANK_LSB+:1] == 1'b0 ? 2'd0 : 2'd1)
      2'd0:    blank_len = 16'h0000;
      default: blank_len = BLANK_CYC1;
    endcase
  end
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      bcnt_q      <= '0;
      o_csa_blank <= 1'b0;
    end else begin
      if (|(o_gate_drive ^ (i_pwm_cmd & ~{6{fault_q | any_fault}})) && blank_len != 16'h0) begin
        bcnt_q      <= blank_len;
        o_csa_blank <= 1'b1;
      end else if (bcnt_q > 16'h0001) begin
        bcnt_q <= bcnt_q - 16'h0001;
      end else begin
        bcnt_q      <= '0;
        o_csa_blank <= 1'b0;
      end
    end
  end

  // Drive outputs.
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_gate_drive       <= '0;
      o_hold_current     <= '0;
      o_gate_hiz         <= 6'h3f;
      o_csa_gain         <= '0;
      o_csa_bias_quarter <= 1'b0;
      o_csa_cal          <= '0;
    end else begin
      o_gate_drive <= (fault_q || any_fault) ? 6'h00 : i_pwm_cmd;
      o_gate_hiz   <= {6{fault_q || any_fault}};
      for (int g = 0; g < 6; g++) begin
        o_hold_current[g] <= (gst_q[g] == GD_HOLD);
      end
      o_csa_gain         <= csa_q[5:0];
      o_csa_bias_quarter <= csa_q[BIAS_BIT];
      o_csa_cal          <= csa_q[CAL_LSB+:3];
    end
  end

  // Read port.
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      if (i_addr == ADDR_STAT1) begin
        o_rdata <= {5'h00, fault_q, 1'b0, ftype_q, gfail_q};
      end else if (i_addr == ADDR_STAT2) begin
        o_rdata <= {10'h000, therm, wstat_q};
      end else if (i_addr == ADDR_LS_DRV) begin
        o_rdata <= ls_drv_q;
      end else if (i_addr == ADDR_HS_DRV) begin
        o_rdata <= hs_drv_q;
      end else if (i_addr == ADDR_CTRL) begin
        o_rdata <= ctrl_q;
      end else if (i_addr == ADDR_CSA) begin
        o_rdata <= {5'h00, csa_q};
      end else begin
        o_rdata <= '0;
      end
    end else begin
      o_rdata <= '0;
    end
  end

  fault_pin_low_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    fault_q |=> o_error_indicator_pin_oe)
    else $error("error pin not low during fault");
  fault_hiz_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    fault_q |=> (o_gate_hiz == 6'h3f && o_gate_drive == 6'h00))
    else $error("gates not high impedance in fault");
  fault_latch_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (fault_q && !ctrl_q[CLR_BIT] && !(en_prev_q && !en_s)) |=> fault_q)
    else $error("fault released without recovery");
  clr_self_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (clr_done && !(i_wr && i_addr == ADDR_CTRL)) |=> !ctrl_q[CLR_BIT])
    else $error("clear bit did not self clear");
  pgood_low_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (!win_ok && o_supply_good_output) |=> !o_supply_good_output [*8])
    else $error("supply good not held low");
  idle_release_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (!fault_q && !any_fault && !warn_pend) |=> !o_error_indicator_pin_oe)
    else $error("error pin driven with nothing pending");
  ack_stop_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (warn_ack_rd && warn == wstat_q && !fault_q)
      ##1 ($stable(warn) && !fault_q && !any_fault)
      |=> !o_error_indicator_pin_oe)
    else $error("acknowledged warning still reported");
  gate_check_off_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    ctrl_q[GCHK_DIS_BIT] && $stable(ctrl_q) |=> ~|gfail_now)
    else $error("gate fault while check disabled");
endmodule
